// file: design/shimf_regs.sv
// Purpose: event mask, status flags, remaining-word counter and FIFO word
//          window of a memory-card host, as an AXI4-Lite slave.
// Assumes: event, live-state, FIFO and enable inputs are on aclk.
// Notes on behaviour
// RULE_01: mask bits 23:0 enable matching events
// RULE_02: software keeps mask bits 31:24 zero
// RULE_03: counter reports remaining FIFO words, 24 bits
// RULE_04: enable loads length[24:2], plus one unaligned
// RULE_05: a cycle with a push, a pop or both decrements counter by one, holding at zero
// RULE_06: offsets 0x80 to 0xFC reach one FIFO
// RULE_07: FIFO window accessed by whole words only
// RULE_08: write pushes transmit word, read pops receive
// RULE_09: bits 23,22,10:0 sticky; 21:11 live
// RULE_10: interrupt when any enabled flag is set
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "shimf_cfg.svh"

module shimf_regs (
    input  logic                      aclk,
    input  logic                      aresetn,
    input  logic [`SHIMF_ADDR_W-1:0]  s_axi_awaddr,
    input  logic                      s_axi_awvalid,
    output logic                      s_axi_awready,
    input  logic [31:0]               s_axi_wdata,
    input  logic [3:0]                s_axi_wstrb,
    input  logic                      s_axi_wvalid,
    output logic                      s_axi_wready,
    output shimf_pkg::shimf_resp_t    s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  logic                      s_axi_bready,
    input  logic [`SHIMF_ADDR_W-1:0]  s_axi_araddr,
    input  logic                      s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output shimf_pkg::shimf_resp_t    s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  logic                      s_axi_rready,
    input  logic [`SHIMF_EVT_W-1:0]   event_set,
    input  logic [`SHIMF_LIVE_W-1:0]  live_state,
    input  logic                      data_transfer_enable,
    input  logic [`SHIMF_LEN_W-1:0]   transfer_byte_length,
    output logic                      tx_push,
    output logic [31:0]               tx_fifo_word,
    input  logic [31:0]               rx_fifo_word,
    input  logic                      rx_fifo_valid,
    output logic                      rx_pop,
    output logic [`SHIMF_CNT_W-1:0]   remaining_word_count,
    output logic                      irq
);
    import shimf_pkg::*;

    // write channel state
    logic                     aw_held_q,  aw_held_d;
    logic                     w_held_q,   w_held_d;
    logic [`SHIMF_ADDR_W-1:0] awaddr_q,   awaddr_d;
    logic [31:0]              wdata_q,    wdata_d;
    logic [3:0]               wstrb_q,    wstrb_d;
    logic                     awready_q,  awready_d;
    logic                     wready_q,   wready_d;
    logic                     bvalid_q,   bvalid_d;
    shimf_resp_t              bresp_q,    bresp_d;

    // read channel state
    logic                     arready_q,  arready_d;
    logic                     rvalid_q,   rvalid_d;
    logic [31:0]              rdata_q,    rdata_d;
    shimf_resp_t              rresp_q,    rresp_d;

    // block state
    logic [`SHIMF_EVT_W-1:0]  mask_q,     mask_d;
    logic [`SHIMF_EVT_W-1:0]  status_q,   status_d;
    logic [`SHIMF_EVT_W-1:0]  clear_d;
    logic                     tx_push_q,  tx_push_d;
    logic [31:0]              tx_word_q,  tx_word_d;
    logic                     rx_pop_q,   rx_pop_d;
    logic                     irq_q,      irq_d;
    logic                     xfer_en_q;
    logic                     count_load;
    logic [`SHIMF_CNT_W-1:0]  count;

    logic                     do_write;
    shimf_sel_t               wr_sel;
    shimf_sel_t               rd_sel;

    assign do_write   = aw_held_q && w_held_q && !bvalid_q;
    assign wr_sel     = shimf_decode(awaddr_q);
    assign rd_sel     = shimf_decode(s_axi_araddr);
    assign count_load = data_transfer_enable && !xfer_en_q;

    // register bus: address and data may arrive in either order
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        mask_d    = mask_q;
        clear_d   = '0;
        tx_push_d = 1'b0;
        tx_word_d = tx_word_q;
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        rx_pop_d  = 1'b0;

        if (s_axi_awvalid && awready_q) begin
            aw_held_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_held_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;

        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = SHIMF_RESP_OKAY;
            unique case (wr_sel)
                SHIMF_SEL_MASK: begin
                    // upper byte is reserved and never stored
                    for (int b = 0; b < 3; b++) begin
                        if (wstrb_q[b])
                            mask_d[8*b +: 8] = wdata_q[8*b +: 8]; // RULE_01
                    end
                end
                SHIMF_SEL_CLR: begin
                    for (int b = 0; b < 3; b++) begin
                        if (wstrb_q[b])
                            clear_d[8*b +: 8] = wdata_q[8*b +: 8];
                    end
                end
                SHIMF_SEL_FIFO: begin
                    // partial words would corrupt the stream, so refuse them
                    if (wstrb_q == `SHIMF_FULL_STRB) begin
                        tx_push_d = 1'b1; // RULE_08
                        tx_word_d = wdata_q; // RULE_06
                    end else begin
                        bresp_d = SHIMF_RESP_SLVERR; // RULE_07
                    end
                end
                SHIMF_SEL_STAT,
                SHIMF_SEL_CNT: begin
                    bresp_d = SHIMF_RESP_OKAY;
                end
                SHIMF_SEL_NONE: begin
                    bresp_d = SHIMF_RESP_SLVERR;
                end
            endcase
        end

        if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;

        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d  = `SHIMF_WORD_RST;
            rresp_d  = SHIMF_RESP_OKAY;
            unique case (rd_sel)
                SHIMF_SEL_STAT:
                    rdata_d = {8'h00, status_q};
                SHIMF_SEL_MASK:
                    rdata_d = {8'h00, mask_q};
                SHIMF_SEL_CNT:
                    rdata_d = {8'h00, count}; // RULE_03
                SHIMF_SEL_FIFO: begin
                    // empty receive side reads zero and pops nothing
                    if (rx_fifo_valid) begin
                        rdata_d  = rx_fifo_word; // RULE_08
                        rx_pop_d = 1'b1; // RULE_06
                    end
                end
                SHIMF_SEL_CLR: begin
                    rdata_d = `SHIMF_WORD_RST;
                end
                SHIMF_SEL_NONE: begin
                    rresp_d = SHIMF_RESP_SLVERR;
                end
            endcase
        end

        awready_d = !aw_held_d;
        wready_d  = !w_held_d;
        arready_d = !rvalid_d;
    end

    // status flags and interrupt
    always_comb begin
        // set wins over a clear landing in the same cycle
        status_d = ((status_q & ~clear_d) | event_set) & `SHIMF_STICKY_MASK; // RULE_09
        status_d[`SHIMF_LIVE_LSB +: `SHIMF_LIVE_W] = live_state; // RULE_09
        irq_d    = |(status_q & mask_q); // RULE_10
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= `SHIMF_WORD_RST;
            wstrb_q   <= '0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= SHIMF_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= `SHIMF_WORD_RST;
            rresp_q   <= SHIMF_RESP_OKAY;
            mask_q    <= `SHIMF_MASK_RST;
            status_q  <= `SHIMF_STAT_RST;
            tx_push_q <= 1'b0;
            tx_word_q <= `SHIMF_WORD_RST;
            rx_pop_q  <= 1'b0;
            irq_q     <= 1'b0;
            xfer_en_q <= 1'b0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            mask_q    <= mask_d;
            status_q  <= status_d;
            tx_push_q <= tx_push_d;
            tx_word_q <= tx_word_d;
            rx_pop_q  <= rx_pop_d;
            irq_q     <= irq_d;
            xfer_en_q <= data_transfer_enable;
        end
    end

    // counter sees the bus-side word strobes one cycle after the access
    shimf_word_counter #(
        .CNT_W (`SHIMF_CNT_W),
        .LEN_W (`SHIMF_LEN_W)
    ) u_word_counter (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (count_load), // RULE_04
        .byte_len (transfer_byte_length),
        .dec      (tx_push_q || rx_pop_q), // RULE_05
        .count    (count)
    );

    assign s_axi_awready        = awready_q;
    assign s_axi_wready         = wready_q;
    assign s_axi_bvalid         = bvalid_q;
    assign s_axi_bresp          = bresp_q;
    assign s_axi_arready        = arready_q;
    assign s_axi_rvalid         = rvalid_q;
    assign s_axi_rdata          = rdata_q;
    assign s_axi_rresp          = rresp_q;
    assign tx_push              = tx_push_q;
    assign tx_fifo_word         = tx_word_q;
    assign rx_pop               = rx_pop_q;
    assign remaining_word_count = count;
    assign irq                  = irq_q;

endmodule // shimf_regs

// file: pkg/shimf_cfg.svh
// Purpose: offsets, field positions, reset values and fixed widths of the
//          card host interrupt mask / FIFO counter / FIFO port register tail.
// Assumes: byte addresses on a 32-bit register bus, one word per register.
// Notes:   definitions only.
`ifndef SHIMF_CFG_SVH
`define SHIMF_CFG_SVH

`define SHIMF_ADDR_W         8
`define SHIMF_STAT_OFF       8'h34
`define SHIMF_CLR_OFF        8'h38
`define SHIMF_MASK_OFF       8'h3C
`define SHIMF_CNT_OFF        8'h48
`define SHIMF_FIFO_OFF       8'h80
`define SHIMF_FIFO_LAST      8'hFC
`define SHIMF_FIFO_SEL_BIT   7
`define SHIMF_EVT_W          24
`define SHIMF_LIVE_LSB       11
`define SHIMF_LIVE_W         11
`define SHIMF_STICKY_MASK    24'hC007FF
`define SHIMF_MASK_RST       24'h000000
`define SHIMF_STAT_RST       24'h000000
`define SHIMF_CNT_W          24
`define SHIMF_LEN_W          25
`define SHIMF_CNT_RST        24'h000000
`define SHIMF_WORD_RST       32'h00000000
`define SHIMF_FULL_STRB      4'hF

`endif

// file: pkg/shimf_pkg.sv
// Purpose: shared types and the register decode of the register tail.
// Assumes: shimf_cfg.svh on the include path.
// Notes:   decode is used by both the write and the read path.
`include "shimf_cfg.svh"

package shimf_pkg;

    typedef enum logic [1:0] {
        SHIMF_RESP_OKAY   = 2'h0,
        SHIMF_RESP_SLVERR = 2'h2
    } shimf_resp_t;

    typedef enum {
        SHIMF_SEL_NONE,
        SHIMF_SEL_STAT,
        SHIMF_SEL_CLR,
        SHIMF_SEL_MASK,
        SHIMF_SEL_CNT,
        SHIMF_SEL_FIFO
    } shimf_sel_t;

    function automatic shimf_sel_t shimf_decode(input logic [`SHIMF_ADDR_W-1:0] addr);
        logic [`SHIMF_ADDR_W-1:0] word;
        word = {addr[`SHIMF_ADDR_W-1:2], 2'h0};
        if (addr[`SHIMF_FIFO_SEL_BIT])
            return SHIMF_SEL_FIFO;
        else if (word == `SHIMF_STAT_OFF)
            return SHIMF_SEL_STAT;
        else if (word == `SHIMF_CLR_OFF)
            return SHIMF_SEL_CLR;
        else if (word == `SHIMF_MASK_OFF)
            return SHIMF_SEL_MASK;
        else if (word == `SHIMF_CNT_OFF)
            return SHIMF_SEL_CNT;
        else
            return SHIMF_SEL_NONE;
    endfunction

endpackage

// file: design/shimf_word_counter.sv
// Purpose: remaining-word counter of the current transfer.
// Assumes: load and dec are single-cycle strobes on aclk.
// Notes:   load beats dec in the same cycle; counter holds at zero.
`timescale 1ns/10ps
`include "shimf_cfg.svh"

module shimf_word_counter #(
    parameter int CNT_W = `SHIMF_CNT_W,
    parameter int LEN_W = `SHIMF_LEN_W
) (
    input  logic             aclk,
    input  logic             aresetn,
    input  logic             load,
    input  logic [LEN_W-1:0] byte_len,
    input  logic             dec,
    output logic [CNT_W-1:0] count
);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;

    always_comb begin
        count_d = count_q;
        if (load) begin
            // partial trailing word still occupies one FIFO word
            count_d = CNT_W'(byte_len[LEN_W-1:2]) + CNT_W'(|byte_len[1:0]); // RULE_04
        end else if (dec && (count_q != '0)) begin
            count_d = count_q - CNT_W'(1); // RULE_05
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            count_q <= `SHIMF_CNT_RST;
        else
            count_q <= count_d;
    end

    assign count = count_q;

endmodule // shimf_word_counter

// file: testbench/shimf_regs_properties.sv
// Purpose: port-level checks of the register tail.
// Assumes: one clock, aresetn synchronous active low.
// Notes: irq and status bits are judged by the bench.
`timescale 1ns/10ps
module shimf_regs_properties
    import shimf_pkg::*;
(
    input logic        aclk,
    input logic        aresetn,
    input logic [7:0]  s_axi_awaddr,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0]  s_axi_wstrb,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input shimf_resp_t s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        data_transfer_enable,
    input logic [24:0] transfer_byte_length,
    input logic        tx_push,
    input logic [31:0] tx_fifo_word,
    input logic [31:0] rx_fifo_word,
    input logic        rx_fifo_valid,
    input logic        rx_pop,
    input logic [23:0] remaining_word_count
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic fw_go;
    logic ar_go;
    // a pending response delays the write, so only the clean case is timed
    assign fw_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid && s_axi_awaddr[7];
    assign ar_go = s_axi_arvalid && s_axi_arready;
    a_push_pulse: assert property (tx_push |=> !tx_push) else $error("push wider than a cycle");
    a_pop_word: assert property (rx_pop |-> s_axi_rdata == $past(rx_fifo_word)) else $error("popped word lost");
    a_empty_read: assert property (ar_go && s_axi_araddr[7] && !rx_fifo_valid |=> !rx_pop && s_axi_rdata == 32'h0)
        else $error("read of empty fifo popped");
    a_fifo_write: assert property (fw_go && s_axi_wstrb == 4'hF |-> ##2 tx_push && tx_fifo_word == $past(s_axi_wdata, 2))
        else $error("fifo window write not pushed");
    a_part_write: assert property (fw_go && s_axi_wstrb != 4'hF |-> ##2 !tx_push && s_axi_bresp == SHIMF_RESP_SLVERR)
        else $error("partial fifo write accepted");
    a_count_load: assert property ($rose(data_transfer_enable) |=> remaining_word_count ==
        24'($past(transfer_byte_length[24:2])) + 24'($past(|transfer_byte_length[1:0]))) else $error("bad count load");
    a_count_step: assert property ((tx_push || rx_pop) && remaining_word_count != 0 && !$rose(data_transfer_enable)
        |=> remaining_word_count == $past(remaining_word_count) - 24'h1) else $error("count did not step");
    a_count_read: assert property (ar_go && s_axi_araddr == 8'h48 |=> s_axi_rdata == {8'h00, $past(remaining_word_count)})
        else $error("count read mismatch");
    c_push: cover property (tx_push);
    c_pop: cover property (rx_pop);
    c_load: cover property ($rose(data_transfer_enable));
endmodule // shimf_regs_properties

bind shimf_regs shimf_regs_properties u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .data_transfer_enable, .transfer_byte_length, .tx_push,
    .tx_fifo_word, .rx_fifo_word, .rx_fifo_valid, .rx_pop, .remaining_word_count);

// file: testbench/shimf_fifo_partner.sv
// Purpose: far-side fifos: receive words offered, transmit words kept.
// Assumes: show-ahead receive head; one-cycle push and pop strobes.
// Notes: head toggles while empty so stale data is never trusted.
`timescale 1ns/10ps
module shimf_fifo_partner (
    input  logic        aclk,
    input  logic        aresetn,
    input  logic        fill,
    input  logic [31:0] fill_word,
    input  logic        rx_pop,
    input  logic        tx_push,
    input  logic [31:0] tx_fifo_word,
    output logic [31:0] rx_fifo_word = 32'h0,
    output logic        rx_fifo_valid = 1'b0
);
    logic [31:0] rxq [$];
    logic [31:0] txq [$];
    always @(posedge aclk) begin
        if (!aresetn) begin
            rxq.delete();
            txq.delete();
        end else begin
            if (rx_pop && rxq.size() > 0) void'(rxq.pop_front());
            if (tx_push) txq.push_back(tx_fifo_word);
            if (fill) rxq.push_back(fill_word);
        end
        rx_fifo_valid <= rxq.size() > 0;
        rx_fifo_word <= (rxq.size() > 0) ? rxq[0] : ~rx_fifo_word;
    end
endmodule // shimf_fifo_partner

// file: testbench/test_sd_host_irq_mask_and_fifo_port.sv
// Purpose: self-checking bench of the register tail.
// Assumes: partner model plays both fifos; events driven here.
// Notes: xorshift stimulus from a fixed seed.
`timescale 1ns/10ps
`include "shimf_cfg.svh"
module test_sd_host_irq_mask_and_fifo_port;
    import shimf_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, fill = 1'b0, data_transfer_enable = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, fill_word = 32'h0, seed = 32'hB09D, s_axi_rdata, tx_fifo_word, rx_fifo_word;
    logic [24:0] transfer_byte_length = 25'h0, lens [4] = '{25'h0, 25'h1, 25'h4, 25'h1FFFFFF};
    logic [23:0] event_set = 24'h0, remaining_word_count;
    logic [10:0] live_state = 11'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_push, rx_pop, rx_fifo_valid, irq;
    shimf_resp_t s_axi_bresp, s_axi_rresp;
    int fails = 0, checks_done = 0, cyc = 0;
    shimf_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_set, .live_state,
        .data_transfer_enable, .transfer_byte_length, .tx_push, .tx_fifo_word, .rx_fifo_word, .rx_fifo_valid,
        .rx_pop, .remaining_word_count, .irq);
    shimf_fifo_partner u_far (.aclk, .aresetn, .fill, .fill_word, .rx_pop, .tx_push, .tx_fifo_word,
        .rx_fifo_word, .rx_fifo_valid);
    always #50 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] exp_cnt(input logic [24:0] n);
        return 32'(n[24:2]) + 32'(n[1:0] != 2'h0);
    endfunction
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", n, exp, got);
        end
    endtask
    // both channels offered together; each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic load(input logic [24:0] n);
        @(posedge aclk);
        transfer_byte_length <= n;
        data_transfer_enable <= 1'b1;
        @(posedge aclk);
        data_transfer_enable <= 1'b0;
    endtask
    task results();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        logic [31:0] d, v, e [4];
        logic [1:0] r;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h48, d, r);
        chk("count reset", d, 32'h0);
        rd(8'h10, d, r);
        chk("unmapped resp", 32'(r), 32'(SHIMF_RESP_SLVERR));
        v = rnd() & 32'h00FFFFFF;
        wr(`SHIMF_MASK_OFF, v, 4'hF, r);
        rd(`SHIMF_MASK_OFF, d, r);
        chk("mask", d, v);
        for (int i = 0; i < 8; i++) begin
            load(i < 4 ? lens[i] : 25'(rnd()));
            rd(8'h48, d, r);
            chk("count load", d, exp_cnt(transfer_byte_length));
        end
        load(25'd30);
        for (int k = 0; k < 4; k++) begin
            v = rnd();
            e[k] = rnd();
            wr(k == 0 ? 8'hFC : {1'b1, v[4:0], 2'h0}, e[k], 4'hF, r);
        end
        wr(8'h80, v, 4'h3, r);
        chk("partial resp", 32'(r), 32'(SHIMF_RESP_SLVERR));
        rd(8'h48, d, r);
        chk("count after push", d, exp_cnt(25'd30) - 4);
        chk("tx depth", u_far.txq.size(), 4);
        foreach (e[k]) chk("tx word", u_far.txq[k], e[k]);
        for (int k = 0; k < 4; k++) begin
            @(posedge aclk);
            e[k] = rnd();
            fill_word <= e[k];
            fill <= k < 3;
        end
        // fourth read finds the receive side empty
        for (int k = 0; k < 4; k++) begin
            v = rnd();
            rd({1'b1, v[4:0], 2'h0}, d, r);
            chk("rx word", d, k < 3 ? e[k] : 32'h0);
        end
        rd(8'h48, d, r);
        chk("count after pop", d, exp_cnt(25'd30) - 7);
        // random mask from above would let the first event through
        wr(`SHIMF_MASK_OFF, 32'h0, 4'hF, r);
        // previous bit stays enabled, so each new event is first seen masked
        for (int i = 0; i < 24; i++) begin
            v = 32'h1 << i;
            @(posedge aclk);
            if (`SHIMF_STICKY_MASK & v[23:0]) event_set <= v[23:0];
            else live_state <= v[21:11];
            @(posedge aclk);
            event_set <= 24'h0;
            repeat (4) @(posedge aclk);
            chk("irq masked", irq, 32'h0);
            rd(`SHIMF_STAT_OFF, d, r);
            chk("status", d, v);
            wr(`SHIMF_MASK_OFF, v, 4'hF, r);
            repeat (4) @(posedge aclk);
            chk("irq", irq, 32'h1);
            if (`SHIMF_STICKY_MASK & v[23:0]) begin
                wr(`SHIMF_CLR_OFF, v, 4'hF, r);
            end else begin
                @(posedge aclk);
                live_state <= 11'h0;
            end
            repeat (4) @(posedge aclk);
            chk("irq cleared", irq, 32'h0);
            rd(`SHIMF_STAT_OFF, d, r);
            chk("status cleared", d, 32'h0);
        end
        // read-only register ignores a write, clear register reads zero
        wr(`SHIMF_CNT_OFF, 32'h00FFFFFF, 4'hF, r);
        chk("ro write resp", 32'(r), 32'(SHIMF_RESP_OKAY));
        rd(8'h48, d, r);
        chk("count after ro write", d, exp_cnt(25'd30) - 7);
        rd(`SHIMF_CLR_OFF, d, r);
        chk("clear reads zero", d, 32'h0);
        // second reset in mid-run brings mask and counter back to zero
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`SHIMF_MASK_OFF, d, r);
        chk("mask after reset", d, 32'h0);
        rd(8'h48, d, r);
        chk("count after reset", d, 32'h0);
        results();
    end
endmodule // test_sd_host_irq_mask_and_fifo_port
